//--- ivp_core.sv
// Notes on behaviour
// R01: group A vectors fffa, below trap, wakes halt
// R02: group B vectors fff8, below A, wakes halt
// R03: clock monitor vectors fff6 below groups
// R04: serial fff4, timer A fff2, no halt wake
// R05: timer B ffee, two-wire ffe4, no halt wake
// R06: reset first, trap next, then table order
// R07: reset enters run, clock divided by two
// R08: slow mode divides by 4 to 32
// R09: wait during slow keeps slow clock
// R10: wait stops cpu, peripherals keep running
// R11: entering wait clears interrupt mask
// R12: wait ends on any interrupt or reset
// R13: service sets mask, return clears it
// R14: halt stops oscillator, cpu and peripherals
// R15: halt left only on reset, external groups
// R16: halt exit waits 4096 cpu cycles
// R17: after start-up, service waking interrupt
// R18: entering halt clears mask, pending wakes
// R19: watchdog option may turn halt into reset
// R20: selected pins of a group are anded
// R21: external latch cleared on vector fetch
// R22: software clears latch by changing sensitivity
// R23: simultaneous requests served by fixed priority
// R24: maskable served only unmasked and enabled
`timescale 1ns/1ps
`default_nettype none
module ivp_core #(
   parameter int STARTUP_CYCLES = ivp_pkg::STARTUP_CYCLES_DOC,
   parameter int PINS_A = 8,
   parameter int PINS_B = 8
) (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic ce_in,
   input wire logic [ivp_pkg::AW-1:0] addr_in,
   input wire logic [ivp_pkg::DW-1:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [ivp_pkg::DW-1:0] rdata_out,
   input wire logic wfi_in,
   input wire logic halt_in,
   input wire logic trap_in,
   input wire logic iret_in,
   input wire logic vec_ack_in,
   input wire logic [PINS_A-1:0] ext_a_pins_in,
   input wire logic [PINS_A-1:0] ext_a_sel_in,
   input wire logic [PINS_B-1:0] ext_b_pins_in,
   input wire logic [PINS_B-1:0] ext_b_sel_in,
   input wire logic css_event_in,
   input wire logic serial_irq_in,
   input wire logic timer_a_irq_in,
   input wire logic timer_b_irq_in,
   input wire logic two_wire_irq_in,
   input wire logic wdg_enabled_in,
   input wire logic wdg_halt_option_in,
   output logic irq_req_out,
   output logic [15:0] vector_out,
   output logic i_bit_out,
   output logic cpu_clk_en_out,
   output logic periph_clk_en_out,
   output logic osc_on_out,
   output logic wdg_reset_out,
   output logic [2:0] mode_out
);
   import ivp_pkg::*;

   typedef struct packed {
      ivp_mode_e mode;
      logic i_bit;
      logic irq_req;
      logic [15:0] vec;
      logic trap_pend;
      logic ext_a_pend;
      logic ext_b_pend;
      logic ext_a_prev;
      logic ext_b_prev;
      logic [1:0] sens_a;
      logic [1:0] sens_b;
      logic slow;
      logic div_low;
      logic div_high;
      logic css_en;
      logic css_flag;
      logic [STARTUP_W-1:0] startup_cnt;
      logic wdg_rst;
      logic cpu_en;
      logic periph_en;
      logic osc_on;
      logic [DW-1:0] rdata;
      logic [2:0] mode_code;
   } ivp_core_s;

   ivp_core_s cur_ff;
   ivp_core_s nxt_cur;
   logic tick;
   logic lvl_a;
   logic lvl_b;
   logic [7:0] req;
   logic avail;
   logic [15:0] best;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // pins not selected as interrupt inputs read as high, so they never mask the group
   function automatic logic grp_level(input logic [PINS_A+PINS_B-1:0] pins, input logic [PINS_A+PINS_B-1:0] sel);
      grp_level = &(pins | ~sel);
   endfunction : grp_level

   function automatic logic ext_event(input logic [1:0] sens, input logic prev, input logic now);
      case (sens)
         SENS_FALL_LOW: ext_event = !now;
         SENS_RISE: ext_event = !prev && now;
         SENS_FALL: ext_event = prev && !now;
         default: ext_event = prev != now;
      endcase
   endfunction : ext_event

   function automatic logic [15:0] pick_vec(input logic [7:0] r);
      if (r[RQ_TRAP]) begin
         pick_vec = VEC_TRAP;
      end else if (r[RQ_EXT_A]) begin
         pick_vec = VEC_EXT_A;
      end else if (r[RQ_EXT_B]) begin
         pick_vec = VEC_EXT_B;
      end else if (r[RQ_CSS]) begin
         pick_vec = VEC_CSS;
      end else if (r[RQ_SERIAL]) begin
         pick_vec = VEC_SERIAL;
      end else if (r[RQ_TIMER_A]) begin
         pick_vec = VEC_TIMER_A;
      end else if (r[RQ_TIMER_B]) begin
         pick_vec = VEC_TIMER_B;
      end else begin
         pick_vec = VEC_TWO_WIRE;
      end
   endfunction : pick_vec

   ivp_prescaler u_pre (
      .clk_sys_in(clk_sys_in),
      .sys_rst_in(sys_rst_in),
      .ce_in(ce_in),
      .slow_in(cur_ff.slow),
      .div_sel_in({cur_ff.div_high, cur_ff.div_low}),
      .tick_out(tick)
   );

   // ----------------------------------------
   // request collection
   // ----------------------------------------
   assign lvl_a = grp_level((PINS_A+PINS_B)'(ext_a_pins_in), (PINS_A+PINS_B)'(ext_a_sel_in)); // [R20]
   assign lvl_b = grp_level((PINS_A+PINS_B)'(ext_b_pins_in), (PINS_A+PINS_B)'(ext_b_sel_in)); // [R20]

   always_comb begin
      req = 8'h00;
      req[RQ_TRAP] = cur_ff.trap_pend;
      req[RQ_EXT_A] = cur_ff.ext_a_pend && !cur_ff.i_bit; // [R24]
      req[RQ_EXT_B] = cur_ff.ext_b_pend && !cur_ff.i_bit;
      req[RQ_CSS] = cur_ff.css_flag && cur_ff.css_en && !cur_ff.i_bit; // [R03] [R24]
      req[RQ_SERIAL] = serial_irq_in && !cur_ff.i_bit;
      req[RQ_TIMER_A] = timer_a_irq_in && !cur_ff.i_bit;
      req[RQ_TIMER_B] = timer_b_irq_in && !cur_ff.i_bit;
      req[RQ_TWO_WIRE] = two_wire_irq_in && !cur_ff.i_bit;
      avail = |req;
      best = pick_vec(req); // [R01] [R02] [R04] [R05] [R06] [R23]
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.wdg_rst = 1'b0;
      nxt_cur.rdata = '0;
      nxt_cur.ext_a_prev = lvl_a;
      nxt_cur.ext_b_prev = lvl_b;
      // register writes; a sensitivity change drops a stale latch
      if (wr_in && addr_in == ADDR_MISC_CTRL) begin
         nxt_cur.sens_a = wdata_in[MC_SENS_A_LO +: 2];
         nxt_cur.sens_b = wdata_in[MC_SENS_B_LO +: 2];
         nxt_cur.div_low = wdata_in[MC_DIV_LOW];
         nxt_cur.div_high = wdata_in[MC_DIV_HIGH];
         nxt_cur.slow = wdata_in[MC_SLOW]; // [R08]
         if (wdata_in[MC_SENS_A_LO +: 2] != cur_ff.sens_a) begin
            nxt_cur.ext_a_pend = 1'b0; // [R22]
         end
         if (wdata_in[MC_SENS_B_LO +: 2] != cur_ff.sens_b) begin
            nxt_cur.ext_b_pend = 1'b0; // [R22]
         end
      end else if (wr_in && addr_in == ADDR_CLK_STATUS) begin
         nxt_cur.css_en = wdata_in[CS_IE];
      end
      // register reads
      if (rd_in && addr_in == ADDR_MISC_CTRL) begin
         nxt_cur.rdata[MC_SENS_A_LO +: 2] = cur_ff.sens_a;
         nxt_cur.rdata[MC_SENS_B_LO +: 2] = cur_ff.sens_b;
         nxt_cur.rdata[MC_DIV_LOW] = cur_ff.div_low;
         nxt_cur.rdata[MC_DIV_HIGH] = cur_ff.div_high;
         nxt_cur.rdata[MC_SLOW] = cur_ff.slow;
      end else if (rd_in && addr_in == ADDR_CLK_STATUS) begin
         nxt_cur.rdata[CS_IE] = cur_ff.css_en;
         nxt_cur.rdata[CS_FLAG] = cur_ff.css_flag;
         if (!css_event_in) begin
            nxt_cur.css_flag = 1'b0;
         end
      end else if (rd_in && addr_in == ADDR_PEND_STATUS) begin
         nxt_cur.rdata = {cur_ff.i_bit, req[7:RQ_EXT_A]};
      end else if (rd_in && addr_in == ADDR_MODE_STATUS) begin
         nxt_cur.rdata[2:0] = cur_ff.mode_code;
      end
      // vector fetch by the cpu
      if (vec_ack_in && cur_ff.irq_req) begin
         nxt_cur.irq_req = 1'b0;
         nxt_cur.i_bit = 1'b1; // [R13]
         if (cur_ff.vec == VEC_TRAP) begin
            nxt_cur.trap_pend = 1'b0;
         end
         if (cur_ff.vec == VEC_EXT_A) begin
            nxt_cur.ext_a_pend = 1'b0; // [R21]
         end
         if (cur_ff.vec == VEC_EXT_B) begin
            nxt_cur.ext_b_pend = 1'b0; // [R21]
         end
         if (cur_ff.mode == M_RST_FETCH) begin
            nxt_cur.mode = M_RUN; // [R07]
         end
      end else if (iret_in) begin
         nxt_cur.i_bit = 1'b0; // [R13]
      end
      // hardware sets win over any clear above; edge logic keeps running in halt
      if (ext_event(cur_ff.sens_a, cur_ff.ext_a_prev, lvl_a)) begin
         nxt_cur.ext_a_pend = 1'b1; // [R01]
      end
      if (ext_event(cur_ff.sens_b, cur_ff.ext_b_prev, lvl_b)) begin
         nxt_cur.ext_b_pend = 1'b1; // [R02]
      end
      if (css_event_in) begin
         nxt_cur.css_flag = 1'b1;
      end
      if (trap_in) begin
         nxt_cur.trap_pend = 1'b1;
      end
      // mode sequencing
      case (cur_ff.mode)
         M_RST_FETCH: begin
            nxt_cur.irq_req = !(vec_ack_in && cur_ff.irq_req);
            nxt_cur.vec = VEC_RESET; // [R06]
         end
         M_RUN: begin
            if (!(vec_ack_in && cur_ff.irq_req)) begin
               nxt_cur.irq_req = avail;
               nxt_cur.vec = best;
            end
            if (wfi_in) begin
               nxt_cur.i_bit = 1'b0; // [R11]
               nxt_cur.irq_req = 1'b0;
               nxt_cur.mode = M_WAIT; // [R09] [R10]
            end else if (halt_in && wdg_enabled_in && !wdg_halt_option_in) begin
               nxt_cur.wdg_rst = 1'b1; // [R19]
            end else if (halt_in) begin
               nxt_cur.i_bit = 1'b0; // [R18]
               nxt_cur.irq_req = 1'b0;
               // a group latch already set means an immediate wake through start-up
               if (cur_ff.ext_a_pend || cur_ff.ext_b_pend) begin
                  nxt_cur.mode = M_STARTUP; // [R18]
                  nxt_cur.startup_cnt = '0;
               end else begin
                  nxt_cur.mode = M_HALT; // [R14]
                  nxt_cur.osc_on = 1'b0;
               end
            end
         end
         M_WAIT: begin
            if (avail) begin
               nxt_cur.mode = M_RUN; // [R12]
            end
         end
         M_HALT: begin
            if (cur_ff.ext_a_pend || cur_ff.ext_b_pend) begin
               nxt_cur.mode = M_STARTUP; // [R15]
               nxt_cur.osc_on = 1'b1; // [R16]
               nxt_cur.startup_cnt = '0;
            end
         end
         default: begin
            // the count is in cpu cycles, so it follows the selected divider
            if (tick) begin
               if (cur_ff.startup_cnt == STARTUP_W'(STARTUP_CYCLES - 1)) begin
                  nxt_cur.mode = M_RUN; // [R16] [R17]
               end else begin
                  nxt_cur.startup_cnt = cur_ff.startup_cnt + 1'b1;
               end
            end
         end
      endcase
      nxt_cur.cpu_en = tick && (nxt_cur.mode == M_RUN || nxt_cur.mode == M_RST_FETCH); // [R10]
      nxt_cur.periph_en = tick && nxt_cur.mode != M_HALT && nxt_cur.mode != M_STARTUP; // [R10] [R14]
      case (nxt_cur.mode)
         M_WAIT: nxt_cur.mode_code = nxt_cur.slow ? MODE_SLOW_WAIT : MODE_WAIT; // [R09]
         M_HALT: nxt_cur.mode_code = MODE_HALT;
         M_STARTUP: nxt_cur.mode_code = MODE_STARTUP;
         default: nxt_cur.mode_code = nxt_cur.slow ? MODE_SLOW : MODE_RUN;
      endcase
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         cur_ff <= '0;
         cur_ff.mode <= M_RST_FETCH; // [R07]
         cur_ff.irq_req <= 1'b1;
         cur_ff.vec <= VEC_RESET;
         cur_ff.i_bit <= 1'b1;
         cur_ff.osc_on <= 1'b1;
         cur_ff.ext_a_prev <= 1'b1;
         cur_ff.ext_b_prev <= 1'b1;
      end else if (ce_in) begin
         cur_ff <= nxt_cur;
      end
   end

   assign rdata_out = cur_ff.rdata;
   assign irq_req_out = cur_ff.irq_req;
   assign vector_out = cur_ff.vec;
   assign i_bit_out = cur_ff.i_bit;
   assign cpu_clk_en_out = cur_ff.cpu_en;
   assign periph_clk_en_out = cur_ff.periph_en;
   assign osc_on_out = cur_ff.osc_on;
   assign wdg_reset_out = cur_ff.wdg_rst;
   assign mode_out = cur_ff.mode_code;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_wait_mask_clear: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // [R11]
      (ce_in && cur_ff.mode == M_RUN && wfi_in) |=> (!i_bit_out && cur_ff.mode == M_WAIT))
      else $error("wait entry did not clear mask");
   a_fetch_sets_mask: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // [R13]
      (ce_in && irq_req_out && vec_ack_in) |=> (i_bit_out && !irq_req_out))
      else $error("vector fetch did not set mask");
   a_masked_no_req: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // [R24]
      (ce_in && cur_ff.mode == M_RUN && cur_ff.i_bit && !cur_ff.trap_pend && !wfi_in) |=> !irq_req_out)
      else $error("masked request was raised");
   a_group_a_first: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // [R23]
      (ce_in && cur_ff.mode == M_RUN && cur_ff.ext_a_pend && cur_ff.ext_b_pend && !cur_ff.i_bit
       && !cur_ff.trap_pend && !vec_ack_in && !wfi_in && !halt_in) |=> (irq_req_out && vector_out == VEC_EXT_A))
      else $error("group A not preferred");
   a_halt_no_wake: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // [R15]
      (ce_in && cur_ff.mode == M_HALT && !cur_ff.ext_a_pend && !cur_ff.ext_b_pend) |=> cur_ff.mode == M_HALT)
      else $error("halt left without wake source");
   a_startup_hold: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // [R16]
      (ce_in && cur_ff.mode == M_STARTUP && cur_ff.startup_cnt != STARTUP_W'(STARTUP_CYCLES - 1))
      |=> (cur_ff.mode == M_STARTUP && !cpu_clk_en_out && osc_on_out))
      else $error("start-up delay cut short");
   a_wdg_halt: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // [R19]
      (ce_in && cur_ff.mode == M_RUN && halt_in && !wfi_in && wdg_enabled_in && !wdg_halt_option_in)
      |=> (wdg_reset_out && cur_ff.mode == M_RUN) ##1 !wdg_reset_out)
      else $error("watchdog halt option ignored");
   a_wait_wakes: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // [R12]
      (ce_in && cur_ff.mode == M_WAIT && avail) |=> (cur_ff.mode == M_RUN && periph_clk_en_out == $past(tick)))
      else $error("wait not left on interrupt");
   a_halt_stops_osc: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // [R14]
      (cur_ff.mode == M_HALT) |-> (!osc_on_out && !periph_clk_en_out && !cpu_clk_en_out))
      else $error("clocks running in halt");
endmodule : ivp_core
`default_nettype wire

//--- ivp_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module ivp_cpu_model (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic irq_req_in,
   input wire logic [3:0] ack_dly_in,
   output logic vec_ack_out
);
   // ----------------------------------------
   // vector fetch
   // ----------------------------------------
   logic [3:0] wait_ff;
   // a slow core lets the request stand, so a late higher request can still land
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in || !irq_req_in || vec_ack_out) begin
         wait_ff <= 4'h0;
         vec_ack_out <= 1'b0;
      end else if (wait_ff == ack_dly_in) begin
         vec_ack_out <= 1'b1;
      end else begin
         wait_ff <= wait_ff + 4'h1;
      end
   end
endmodule : ivp_cpu_model
`default_nettype wire

//--- ivp_pkg.sv
`default_nettype none
package ivp_pkg;
   // ----------------------------------------
   // register bus
   // ----------------------------------------
   localparam int AW = 4;
   localparam int DW = 8;
   localparam logic [AW-1:0] ADDR_MISC_CTRL = 4'h0;
   localparam logic [AW-1:0] ADDR_CLK_STATUS = 4'h1;
   localparam logic [AW-1:0] ADDR_PEND_STATUS = 4'h2;
   localparam logic [AW-1:0] ADDR_MODE_STATUS = 4'h3;
   // misc_control_one fields
   localparam int MC_SENS_A_LO = 0;
   localparam int MC_SENS_B_LO = 2;
   localparam int MC_DIV_LOW = 4;
   localparam int MC_DIV_HIGH = 5;
   localparam int MC_SLOW = 6;
   // clock_supply_status_register fields
   localparam int CS_FLAG = 1;
   localparam int CS_IE = 2;
   // ----------------------------------------
   // sensitivity codes of the external groups
   // ----------------------------------------
   localparam logic [1:0] SENS_FALL_LOW = 2'h0;
   localparam logic [1:0] SENS_RISE = 2'h1;
   localparam logic [1:0] SENS_FALL = 2'h2;
   localparam logic [1:0] SENS_BOTH = 2'h3;
   // ----------------------------------------
   // vectors, low byte address of each pair
   // ----------------------------------------
   localparam logic [15:0] VEC_RESET = 16'hfffe;
   localparam logic [15:0] VEC_TRAP = 16'hfffc;
   localparam logic [15:0] VEC_EXT_A = 16'hfffa;
   localparam logic [15:0] VEC_EXT_B = 16'hfff8;
   localparam logic [15:0] VEC_CSS = 16'hfff6;
   localparam logic [15:0] VEC_SERIAL = 16'hfff4;
   localparam logic [15:0] VEC_TIMER_A = 16'hfff2;
   localparam logic [15:0] VEC_TIMER_B = 16'hffee;
   localparam logic [15:0] VEC_TWO_WIRE = 16'hffe4;
   // request bit positions, lower index wins
   localparam int RQ_TRAP = 0;
   localparam int RQ_EXT_A = 1;
   localparam int RQ_EXT_B = 2;
   localparam int RQ_CSS = 3;
   localparam int RQ_SERIAL = 4;
   localparam int RQ_TIMER_A = 5;
   localparam int RQ_TIMER_B = 6;
   localparam int RQ_TWO_WIRE = 7;
   // ----------------------------------------
   // clocking
   // ----------------------------------------
   localparam logic [5:0] DIV_RUN = 6'h02;
   localparam logic [5:0] DIV_SLOW_BASE = 6'h04;
   localparam int STARTUP_CYCLES_DOC = 4096;
   localparam int STARTUP_W = 16;
   // ----------------------------------------
   // modes
   // ----------------------------------------
   typedef enum logic [2:0] {M_RST_FETCH, M_RUN, M_WAIT, M_HALT, M_STARTUP} ivp_mode_e;
   localparam logic [2:0] MODE_RUN = 3'h0;
   localparam logic [2:0] MODE_SLOW = 3'h1;
   localparam logic [2:0] MODE_WAIT = 3'h2;
   localparam logic [2:0] MODE_SLOW_WAIT = 3'h3;
   localparam logic [2:0] MODE_HALT = 3'h4;
   localparam logic [2:0] MODE_STARTUP = 3'h5;
endpackage : ivp_pkg
`default_nettype wire

//--- ivp_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module ivp_prescaler (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic ce_in,
   input wire logic slow_in,
   input wire logic [1:0] div_sel_in,
   output logic tick_out
);
   import ivp_pkg::*;

   typedef struct packed {
      logic [5:0] cnt;
      logic tick;
   } ivp_pre_s;

   ivp_pre_s cur_ff;
   ivp_pre_s nxt_cur;

   function automatic logic [5:0] div_of(input logic slow, input logic [1:0] sel);
      div_of = slow ? (DIV_SLOW_BASE << sel) : DIV_RUN;
   endfunction : div_of

   // ----------------------------------------
   // divider
   // ----------------------------------------
   // a divider change applies to the count in progress, and the >= compare ends at once a count already past the new divider instead of letting it wrap
   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.tick = 1'b0;
      if (cur_ff.cnt >= div_of(slow_in, div_sel_in) - 6'h01) begin // [R07] [R08]
         nxt_cur.cnt = 6'h00;
         nxt_cur.tick = 1'b1;
      end else begin
         nxt_cur.cnt = cur_ff.cnt + 6'h01;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         cur_ff <= '0;
      end else if (ce_in) begin
         cur_ff <= nxt_cur;
      end
   end

   assign tick_out = cur_ff.tick;
endmodule : ivp_prescaler
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import ivp_pkg::*;
   // ----------------------------------------
   // bench signals
   // ----------------------------------------
   localparam int SC = 4;
   localparam logic [15:0] VT [8] = '{VEC_TRAP, VEC_EXT_A, VEC_EXT_B, VEC_CSS, VEC_SERIAL, VEC_TIMER_A,
      VEC_TIMER_B, VEC_TWO_WIRE};
   logic clk_sys_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [AW-1:0] addr = 4'h0;
   logic [DW-1:0] wdata = 8'h00;
   logic [DW-1:0] rdata;
   logic wr = 1'b0, rd = 1'b0, clock_failure_monitor = 1'b0, ser = 1'b0, tma = 1'b0, tmb = 1'b0, tw = 1'b0;
   logic ce = 1'b1, wen = 1'b0, wopt = 1'b1, ack, irq, ibit, cen, pen, osc, wrst;
   logic [3:0] pl = 4'h0;
   logic [3:0] dly = 4'h0;
   logic [7:0] pa = 8'hff, sa = 8'h01, pb = 8'hff, sb = 8'h01;
   logic [15:0] vec;
   logic [2:0] mode;
   int num_errors = 0;
   int checked = 0;
   always #20 clk_sys_in = ~clk_sys_in;
   ivp_core #(.STARTUP_CYCLES(SC), .PINS_A(8), .PINS_B(8)) dut (
      .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .ce_in(ce),
      .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
      .wfi_in(pl[0]), .halt_in(pl[1]), .trap_in(pl[2]), .iret_in(pl[3]), .vec_ack_in(ack),
      .ext_a_pins_in(pa), .ext_a_sel_in(sa), .ext_b_pins_in(pb), .ext_b_sel_in(sb),
      .css_event_in(clock_failure_monitor), .serial_irq_in(ser), .timer_a_irq_in(tma), .timer_b_irq_in(tmb),
      .two_wire_irq_in(tw), .wdg_enabled_in(wen), .wdg_halt_option_in(wopt),
      .irq_req_out(irq), .vector_out(vec), .i_bit_out(ibit), .cpu_clk_en_out(cen),
      .periph_clk_en_out(pen), .osc_on_out(osc), .wdg_reset_out(wrst), .mode_out(mode)
   );
   ivp_cpu_model cpu (
      .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .irq_req_in(irq), .ack_dly_in(dly),
      .vec_ack_out(ack)
   );
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic stop_test;
      if (num_errors == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_in);
      #1;
   endtask : cyc
   task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge clk_sys_in);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk_sys_in);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [AW-1:0] a, input logic [DW-1:0] e);
      @(posedge clk_sys_in);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk_sys_in);
      rd <= 1'b0;
      #1;
      chk({8'h00, rdata}, {8'h00, e});
   endtask : rd_reg
   // one-cycle instruction strobes: wfi, halt, trap, iret
   task automatic pls(input logic [3:0] m);
      @(posedge clk_sys_in);
      pl <= m;
      @(posedge clk_sys_in);
      pl <= 4'h0;
      #1;
   endtask : pls
   task automatic srv(input logic [15:0] v);
      int n;
      n = 0;
      while (ack !== 1'b1 && n < 300) begin
         cyc(1);
         n++;
      end
      chk(vec, v);
      cyc(1);
      chk({15'h0, ibit}, 16'h1);
   endtask : srv
   // the first interval may straddle a divider change, so the third one is judged
   task automatic per(input logic [15:0] e);
      int n;
      for (int k = 0; k < 3; k++) begin
         n = 0;
         do begin
            cyc(1);
            n++;
         end while (cen !== 1'b1 && n < 99);
      end
      chk(16'(n), e);
   endtask : per
   // ----------------------------------------
   // watchdog
   // ----------------------------------------
   initial begin
      repeat (20000) @(posedge clk_sys_in);
      num_errors++;
      stop_test();
   end
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      int n;
      int m;
      repeat (20) @(posedge clk_sys_in);
      sys_rst_in <= 1'b0;
      #1;
      chk(vec, VEC_RESET);
      srv(VEC_RESET);
      chk(16'(mode), 16'(MODE_RUN));
      per(16'(DIV_RUN));
      rd_reg(ADDR_MISC_CTRL, 8'h00);
      rd_reg(4'h5, 8'h00);
      for (int s = 0; s < 4; s++) begin
         wr_reg(ADDR_MISC_CTRL, 8'h40 | 8'(s << 4));
         per(16'(DIV_SLOW_BASE) << s);
      end
      rd_reg(ADDR_MODE_STATUS, 8'(MODE_SLOW));
      wr_reg(ADDR_MISC_CTRL, 8'h40);
      pls(4'h1);
      chk(16'(mode), 16'(MODE_SLOW_WAIT));
      chk(16'(ibit), 16'h0);
      n = 0;
      m = 0;
      repeat (20) begin
         cyc(1);
         n += cen;
         m += pen;
      end
      chk(16'(n), 16'h0);
      chk(16'(m), 16'h5);
      tma <= 1'b1;
      srv(VEC_TIMER_A);
      tma <= 1'b0;
      wr_reg(ADDR_MISC_CTRL, 8'h0a);
      wr_reg(ADDR_CLK_STATUS, 8'h04);
      rd_reg(ADDR_CLK_STATUS, 8'h04);
      // everything raised while masked, then served one by one
      pa[0] <= 1'b0;
      pb[0] <= 1'b0;
      {clock_failure_monitor, ser, tma, tmb, tw} <= 5'h1f;
      cyc(1);
      clock_failure_monitor <= 1'b0;
      cyc(3);
      chk(16'(irq), 16'h0);
      rd_reg(ADDR_PEND_STATUS, 8'h80);
      dly <= 4'h3;
      pls(4'h4);
      for (int i = 0; i < 8; i++) begin
         srv(VT[i]);
         case (i)
            3: rd_reg(ADDR_CLK_STATUS, 8'h06);
            4: ser <= 1'b0;
            5: tma <= 1'b0;
            6: tmb <= 1'b0;
            7: tw <= 1'b0;
            default: ;
         endcase
         pls(4'h8);
         chk(16'(ibit), 16'h0);
      end
      cyc(4);
      chk(16'(irq), 16'h0);
      pa[0] <= 1'b1;
      pb[0] <= 1'b1;
      dly <= 4'h0;
      pls(4'h2);
      chk(16'(mode), 16'(MODE_HALT));
      cyc(1);
      chk(16'({osc, pen, cen}), 16'h0);
      ser <= 1'b1;
      cyc(10);
      chk(16'(mode), 16'(MODE_HALT));
      pa[0] <= 1'b0;
      n = 0;
      while (mode !== MODE_STARTUP && n < 20) begin
         cyc(1);
         n++;
      end
      cyc(2 * SC - 3);
      chk(16'({osc, mode}), 16'({1'b1, MODE_STARTUP}));
      srv(VEC_EXT_A);
      pls(4'h8);
      srv(VEC_SERIAL);
      ser <= 1'b0;
      pa[0] <= 1'b1;
      cyc(2);
      pa[0] <= 1'b0;
      cyc(3);
      pls(4'h2);
      chk(16'(mode), 16'(MODE_STARTUP));
      srv(VEC_EXT_A);
      pa[0] <= 1'b1;
      wen <= 1'b1;
      wopt <= 1'b0;
      pls(4'h2);
      chk(16'({wrst, mode}), 16'({1'b1, MODE_RUN}));
      wopt <= 1'b1;
      pls(4'h2);
      chk(16'({wrst, mode}), 16'({1'b0, MODE_HALT}));
      pb[0] <= 1'b0;
      srv(VEC_EXT_B);
      pb[0] <= 1'b1;
      wen <= 1'b0;
      pa[0] <= 1'b0;
      cyc(3);
      wr_reg(ADDR_MISC_CTRL, 8'h0b);
      pls(4'h8);
      cyc(4);
      chk(16'(irq), 16'h0);
      wr_reg(ADDR_MISC_CTRL, 8'h09);
      sa <= 8'h03;
      pa[1] <= 1'b0;
      cyc(2);
      pa[0] <= 1'b1;
      cyc(4);
      chk(16'(irq), 16'h0);
      pa[1] <= 1'b1;
      srv(VEC_EXT_A);
      // a write while the enable is low must leave every register as it was
      ce <= 1'b0;
      wr_reg(ADDR_MISC_CTRL, 8'h40);
      ce <= 1'b1;
      rd_reg(ADDR_MISC_CTRL, 8'h09);
      pls(4'h1);
      chk(16'(mode), 16'(MODE_WAIT));
      pb[0] <= 1'b0;
      srv(VEC_EXT_B);
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
